// >>> amp_i2c_control_fault_monitor.sv
`timescale 1ns/1ps
module amp_i2c_control_fault_monitor
    import amp_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_COUNT
) (
    // System clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Serial control link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Control pins
    input wire logic standby_n,
    input wire logic mute,
    // Protection detectors
    input wire logic overcurrent_shutdown,
    input wire logic dc_offset_detect,
    input wire logic thermal_shutdown,
    input wire logic supply_low_detect,
    input wire logic supply_high_detect,
    input wire logic por_detect,
    // Load diagnostics results
    input wire logic short_to_supply,
    input wire logic short_to_ground,
    input wire logic open_load,
    input wire logic shorted_load,
    input wire logic diag_running,
    // Fault pin
    output logic fault_out,
    output logic fault_oe_n,
    // Power stage controls
    output logic output_hiz,
    output logic output_mute,
    output logic [1:0] gain_sel,
    output logic switch_freq_sel,
    output logic [2:0] peak_limit_sel,
    output logic peak_limit_enable
);

    localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

    if (WAKE_CYCLES < 1) begin : g_check
        $error("WAKE_CYCLES must be at least one");
    end

    // System domain state
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [WAKE_W-1:0] wake_cnt_reg;
    logic awake_reg;
    logic sda_prev_reg;
    logic idle_reg;
    logic link_rst_reg;
    logic wr_seen_reg;
    logic rd_seen_reg;
    logic [7:0] fault_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] rd_hold_reg;
    logic hiz_reg;
    logic mute_out_reg;
    logic fault_oe_n_reg;
    logic fault_out_reg;
    logic limit_en_reg;
    logic [7:0] ctrl_out_reg;

    // Link domain state
    link_state_e state_reg;
    link_state_e state_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [7:0] idx_reg;
    logic [7:0] idx_next;
    logic [7:0] wr_data_reg;
    logic [7:0] wr_data_next;
    logic [7:0] wr_idx_reg;
    logic [7:0] wr_idx_next;
    logic wr_tgl_reg;
    logic wr_tgl_next;
    logic rw_reg;
    logic rw_next;
    logic oe_n_reg;
    logic oe_n_next;
    logic sda_zero_reg;
    logic sda_rise_reg;
    logic rd_tgl_reg;
    logic [7:0] rd_idx_reg;

    // Pin synchroniser: every outside level except nrst passes two flops
    wire [SYNC_W-1:0] raw_in = {rd_tgl_reg, wr_tgl_reg, sda_in, scl,
        diag_running, shorted_load, open_load, short_to_ground,
        short_to_supply, por_detect, supply_high_detect, supply_low_detect,
        thermal_shutdown, dc_offset_detect, overcurrent_shutdown, mute,
        standby_n};

    always_ff @(posedge clock) begin
        sync1_reg <= raw_in;
        sync2_reg <= sync1_reg;
    end

    wire por_s = sync2_reg[SY_POR];
    wire uv_s = sync2_reg[SY_UV];
    wire standby_s = ~sync2_reg[SY_STANDBY_N];
    wire mute_s = sync2_reg[SY_MUTE];
    wire scl_s = sync2_reg[SY_SCL];
    wire sda_s = sync2_reg[SY_SDA];
    wire rst_all = ~nrst | por_s;

    // Wake-up delay after standby is released
    wire wake_done = wake_cnt_reg == WAKE_W'(WAKE_CYCLES - 1);

    always_ff @(posedge clock) begin
        if (rst_all || standby_s) begin
            wake_cnt_reg <= '0;
            awake_reg <= 1'b0;
        end else if (wake_done) begin
            awake_reg <= 1'b1;
        end else begin
            wake_cnt_reg <= wake_cnt_reg + 1'b1;
        end
    end

    // Frame watch: start and stop seen from oversampled bus lines
    wire start_cond = scl_s & sda_prev_reg & ~sda_s;
    wire stop_cond = scl_s & ~sda_prev_reg & sda_s;
    wire idle_next = stop_cond | (idle_reg & ~start_cond);

    // The link engine has no clock between frames, so it is held in
    // reset from stop to the next start; the start precedes the first
    // clock fall by far more than three system cycles.
    always_ff @(posedge clock) begin
        if (rst_all) begin
            sda_prev_reg <= 1'b1;
            idle_reg <= 1'b1;
            link_rst_reg <= 1'b1;
        end else begin
            sda_prev_reg <= sda_s;
            idle_reg <= idle_next;
            link_rst_reg <= ~awake_reg | idle_next;
        end
    end

    // Toggle handshakes from the link; toggles fall back to zero while the
    // link is held, so edges are ignored then to avoid false requests.
    wire wr_pulse = (sync2_reg[SY_WR_TGL] ^ wr_seen_reg) & ~link_rst_reg;
    wire rd_pulse = (sync2_reg[SY_RD_TGL] ^ rd_seen_reg) & ~link_rst_reg;
    wire wr_ctrl = wr_pulse & (wr_idx_reg == IDX_CTRL);
    wire rd_fault = rd_pulse & (rd_idx_reg == IDX_FAULT);

    always_ff @(posedge clock) begin
        if (rst_all) begin
            wr_seen_reg <= 1'b0;
            rd_seen_reg <= 1'b0;
        end else begin
            wr_seen_reg <= link_rst_reg ? 1'b0 : sync2_reg[SY_WR_TGL];
            rd_seen_reg <= link_rst_reg ? 1'b0 : sync2_reg[SY_RD_TGL];
        end
    end

    // Protection events and state
    wire diag_fault = sync2_reg[SY_SHORT_SUPPLY] | sync2_reg[SY_SHORT_GND]
        | sync2_reg[SY_SHORTED];
    wire [7:0] events = {sync2_reg[SY_OT], sync2_reg[SY_DC],
        sync2_reg[SY_OV], sync2_reg[SY_UV], sync2_reg[SY_OC], diag_fault,
        2'b00};
    wire fault_active = |events;
    wire playing = awake_reg & ~fault_active & ~sync2_reg[SY_DIAG] & ~mute_s;

    wire [7:0] status_word = {playing, mute_s, sync2_reg[SY_DIAG],
        fault_active, sync2_reg[SY_SHORTED], sync2_reg[SY_OPEN],
        sync2_reg[SY_SHORT_GND], sync2_reg[SY_SHORT_SUPPLY]};

    // Fault bits clear on read; an event in the same cycle still sets.
    wire [7:0] fault_kept = rd_fault ? FAULT_RESET : fault_reg;
    wire [7:0] fault_next = uv_s ? events : (fault_kept | events);

    always_ff @(posedge clock) begin
        if (rst_all) begin
            fault_reg <= FAULT_RESET;
        end else begin
            fault_reg <= fault_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst_all || uv_s) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= wr_data_reg & CTRL_WRITE_MASK;
        end
    end

    // Read data captured once per request, stable until the next one
    wire [7:0] rd_word = (rd_idx_reg == IDX_FAULT) ? fault_reg
        : (rd_idx_reg == IDX_STATUS) ? status_word
        : (rd_idx_reg == IDX_CTRL) ? ctrl_reg
        : 8'h00;

    always_ff @(posedge clock) begin
        if (rst_all) begin
            rd_hold_reg <= 8'h00;
        end else if (rd_pulse) begin
            rd_hold_reg <= rd_word;
        end
    end

    // Power stage and pin outputs
    always_ff @(posedge clock) begin
        if (rst_all) begin
            hiz_reg <= 1'b1;
            mute_out_reg <= 1'b1;
            fault_oe_n_reg <= 1'b1;
            fault_out_reg <= 1'b0;
            limit_en_reg <= 1'b0;
            ctrl_out_reg <= CTRL_RESET;
        end else begin
            hiz_reg <= fault_active | ~awake_reg;
            mute_out_reg <= mute_s | ~awake_reg;
            fault_oe_n_reg <= ~fault_active;
            fault_out_reg <= 1'b0;
            limit_en_reg <= ctrl_reg[CTRL_LIM_LSB +: 3] != LIMIT_OFF;
            ctrl_out_reg <= ctrl_reg;
        end
    end

    assign output_hiz = hiz_reg;
    assign output_mute = mute_out_reg;
    assign fault_oe_n = fault_oe_n_reg;
    assign fault_out = fault_out_reg;
    assign gain_sel = ctrl_out_reg[CTRL_GAIN_LSB +: 2];
    assign switch_freq_sel = ctrl_out_reg[CTRL_FREQ];
    assign peak_limit_sel = ctrl_out_reg[CTRL_LIM_LSB +: 3];
    assign peak_limit_enable = limit_en_reg;

    // Link domain: data sampled on the rising clock edge
    wire want_read = (state_reg == L_ACK_ADDR && rw_reg)
        || state_reg == L_ACK_RDATA;

    always_ff @(posedge scl or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            sda_rise_reg <= 1'b1;
            rd_tgl_reg <= 1'b0;
            rd_idx_reg <= 8'h00;
        end else begin
            sda_rise_reg <= sda_in;
            if (want_read) begin
                rd_tgl_reg <= ~rd_tgl_reg;
                rd_idx_reg <= (state_reg == L_ACK_RDATA)
                    ? idx_reg + 8'h01 : idx_reg;
            end
        end
    end

    // Data high at the rise but low at the fall means a start occurred
    wire start_seen = sda_rise_reg & ~sda_in;
    wire [7:0] byte_in = {shift_reg[6:0], sda_rise_reg};
    wire byte_end = cnt_reg == 3'h7;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        idx_next = idx_reg;
        wr_data_next = wr_data_reg;
        wr_idx_next = wr_idx_reg;
        wr_tgl_next = wr_tgl_reg;
        rw_next = rw_reg;
        oe_n_next = oe_n_reg;
        if (start_seen) begin
            state_next = L_ADDR;
            cnt_next = 3'h0;
            oe_n_next = 1'b1;
        end else begin
            case (state_reg)
                L_ADDR, L_INDEX, L_WDATA: begin
                    shift_next = byte_in;
                    cnt_next = cnt_reg + 3'h1;
                    if (byte_end) begin
                        oe_n_next = 1'b0;
                        if (state_reg == L_ADDR) begin
                            if (byte_in[7:1] == SLAVE_ADDR) begin
                                rw_next = byte_in[0];
                                state_next = L_ACK_ADDR;
                            end else begin
                                oe_n_next = 1'b1;
                                state_next = L_IGNORE;
                            end
                        end else if (state_reg == L_INDEX) begin
                            idx_next = byte_in;
                            state_next = L_ACK_INDEX;
                        end else begin
                            wr_data_next = byte_in;
                            wr_idx_next = idx_reg;
                            wr_tgl_next = ~wr_tgl_reg;
                            idx_next = idx_reg + 8'h01;
                            state_next = L_ACK_WDATA;
                        end
                    end
                end
                L_ACK_ADDR: begin
                    cnt_next = 3'h0;
                    if (rw_reg) begin
                        tx_next = rd_hold_reg;
                        oe_n_next = rd_hold_reg[7];
                        state_next = L_RDATA;
                    end else begin
                        oe_n_next = 1'b1;
                        state_next = L_INDEX;
                    end
                end
                L_ACK_INDEX, L_ACK_WDATA: begin
                    oe_n_next = 1'b1;
                    state_next = L_WDATA;
                end
                L_RDATA: begin
                    cnt_next = cnt_reg + 3'h1;
                    if (byte_end) begin
                        oe_n_next = 1'b1;
                        state_next = L_ACK_RDATA;
                    end else begin
                        tx_next = {tx_reg[6:0], 1'b1};
                        oe_n_next = tx_reg[6];
                    end
                end
                L_ACK_RDATA: begin
                    cnt_next = 3'h0;
                    if (!sda_rise_reg) begin
                        idx_next = rd_idx_reg;
                        tx_next = rd_hold_reg;
                        oe_n_next = rd_hold_reg[7];
                        state_next = L_RDATA;
                    end else begin
                        state_next = L_IGNORE;
                    end
                end
                default: begin
                    oe_n_next = 1'b1;
                end
            endcase
        end
    end

    // Bus drive changes only on the falling clock edge or when the link is reset; SCL is never held.
    always_ff @(negedge scl or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            state_reg <= L_IDLE;
            cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            idx_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            wr_idx_reg <= 8'h00;
            wr_tgl_reg <= 1'b0;
            rw_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            sda_zero_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            idx_reg <= idx_next;
            wr_data_reg <= wr_data_next;
            wr_idx_reg <= wr_idx_next;
            wr_tgl_reg <= wr_tgl_next;
            rw_reg <= rw_next;
            oe_n_reg <= oe_n_next;
            sda_zero_reg <= 1'b0;
        end
    end

    assign sda_oe_n = oe_n_reg;
    assign sda_out = sda_zero_reg;

endmodule // amp_i2c_control_fault_monitor

// >>> amp_pkg.sv
package amp_pkg;

    // Bus identity and register indices
    localparam logic [6:0] SLAVE_ADDR = 7'h6C;
    localparam logic [7:0] IDX_FAULT = 8'h01;
    localparam logic [7:0] IDX_STATUS = 8'h02;
    localparam logic [7:0] IDX_CTRL = 8'h03;

    // Latched fault register bit positions
    localparam int FLT_DIAG = 2;
    localparam int FLT_OC = 3;
    localparam int FLT_UV = 4;
    localparam int FLT_OV = 5;
    localparam int FLT_DC = 6;
    localparam int FLT_OT = 7;
    localparam logic [7:0] FAULT_RESET = 8'h00;

    // Status register bit positions
    localparam int ST_SHORT_SUPPLY = 0;
    localparam int ST_SHORT_GND = 1;
    localparam int ST_OPEN = 2;
    localparam int ST_SHORTED = 3;
    localparam int ST_FAULT = 4;
    localparam int ST_DIAG = 5;
    localparam int ST_MUTE = 6;
    localparam int ST_PLAY = 7;

    // Control register layout
    localparam logic [7:0] CTRL_RESET = 8'h78;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hF9;
    localparam int CTRL_FREQ = 0;
    localparam int CTRL_LIM_LSB = 3;
    localparam int CTRL_GAIN_LSB = 6;
    localparam logic [2:0] LIMIT_OFF = 3'h7;

    // Pin synchroniser lanes
    localparam int SY_STANDBY_N = 0;
    localparam int SY_MUTE = 1;
    localparam int SY_OC = 2;
    localparam int SY_DC = 3;
    localparam int SY_OT = 4;
    localparam int SY_UV = 5;
    localparam int SY_OV = 6;
    localparam int SY_POR = 7;
    localparam int SY_SHORT_SUPPLY = 8;
    localparam int SY_SHORT_GND = 9;
    localparam int SY_OPEN = 10;
    localparam int SY_SHORTED = 11;
    localparam int SY_DIAG = 12;
    localparam int SY_SCL = 13;
    localparam int SY_SDA = 14;
    localparam int SY_WR_TGL = 15;
    localparam int SY_RD_TGL = 16;
    localparam int SYNC_W = 17;

    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam longint WAKE_TIME_PS = 64'd1000000000;
    localparam int WAKE_COUNT = int'(WAKE_TIME_PS / CLK_PERIOD_PS);

    typedef enum logic [3:0] {
        L_IDLE,
        L_ADDR,
        L_ACK_ADDR,
        L_INDEX,
        L_ACK_INDEX,
        L_WDATA,
        L_ACK_WDATA,
        L_RDATA,
        L_ACK_RDATA,
        L_IGNORE
    } link_state_e;

endpackage

// >>> amp_fault_chk.sv
`timescale 1ns/1ps
module amp_fault_chk
    import amp_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_COUNT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Link and control pins
    input wire logic scl,
    input wire logic standby_n,
    input wire logic mute,
    // Detectors
    input wire logic overcurrent_shutdown,
    input wire logic dc_offset_detect,
    input wire logic thermal_shutdown,
    input wire logic supply_low_detect,
    input wire logic supply_high_detect,
    input wire logic por_detect,
    input wire logic short_to_supply,
    input wire logic short_to_ground,
    input wire logic shorted_load,
    // Outputs watched
    input wire logic sda_oe_n,
    input wire logic fault_out,
    input wire logic fault_oe_n,
    input wire logic output_hiz,
    input wire logic output_mute,
    input wire logic [1:0] gain_sel,
    input wire logic switch_freq_sel,
    input wire logic [2:0] peak_limit_sel,
    input wire logic peak_limit_enable
);
    logic evt;
    // Open load is left out: it is reported but never drives the pin
    assign evt = overcurrent_shutdown | dc_offset_detect | thermal_shutdown
        | supply_low_detect | supply_high_detect | short_to_supply
        | short_to_ground | shorted_load;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    AST_RST_DEFAULTS: assert property ($rose(nrst) |->
        gain_sel == 2'b01 && !switch_freq_sel && peak_limit_sel == LIMIT_OFF)
        else $error("control outputs not at defaults after reset");
    AST_FAULT_SET: assert property (
        (evt && !por_detect)[*6] |-> !fault_oe_n)
        else $error("fault pin not driven during event");
    AST_FAULT_CLEAR: assert property ((!evt)[*6] |-> fault_oe_n)
        else $error("fault pin still driven after events ended");
    AST_HIZ_WITH_FAULT: assert property (
        (!fault_oe_n)[*2] |-> output_hiz && !fault_out)
        else $error("outputs not high impedance while faulted");
    AST_MUTE_STOPS: assert property (mute[*5] |-> output_mute)
        else $error("switching not stopped while muted");
    AST_STANDBY_QUIET: assert property ((!standby_n)[*6] |-> sda_oe_n)
        else $error("data line pulled in standby");
    AST_POR_RELEASE: assert property (
        por_detect[*6] |-> sda_oe_n && fault_oe_n)
        else $error("lines not released in power-on reset");
    AST_NO_PULL_SCL_HIGH: assert property (
        scl && $past(scl) |-> !$fell(sda_oe_n))
        else $error("data line pulled while bus clock high");
    AST_PEAK_EN: assert property ($stable(peak_limit_sel)[*2] |->
        peak_limit_enable == (peak_limit_sel != LIMIT_OFF))
        else $error("limiter enable does not follow level");

    cover property (!fault_oe_n);
    cover property ($fell(sda_oe_n));
    cover property ($changed(gain_sel));
endmodule // amp_fault_chk

bind amp_i2c_control_fault_monitor amp_fault_chk #(
    .WAKE_CYCLES(WAKE_CYCLES)
) amp_fault_chk_inst (.clock, .nrst, .scl, .standby_n, .mute,
    .overcurrent_shutdown, .dc_offset_detect, .thermal_shutdown,
    .supply_low_detect, .supply_high_detect, .por_detect, .short_to_supply,
    .short_to_ground, .shorted_load, .sda_oe_n, .fault_out, .fault_oe_n,
    .output_hiz, .output_mute, .gain_sel, .switch_freq_sel, .peak_limit_sel,
    .peak_limit_enable);

// >>> i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
    // Bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // Clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Also serves as repeated start
    task automatic start();
        sda_drv = 1'b1;
        #8 scl = 1'b1;
        #30 sda_drv = 1'b0;
        #30 scl = 1'b0;
        #7;
    endtask
    // Free time after stop keeps frames apart
    task automatic stop();
        sda_drv = 1'b0;
        #8 scl = 1'b1;
        #15 sda_drv = 1'b1;
        #1300;
    endtask
    // Data changes only while clock is low
    // Long high phase: read data crosses back to the link before the fall.
    // Each data change stays over one system cycle away from an SCL edge.
    task automatic xfer_bit(input logic b, output logic s);
        sda_drv = b;
        #6 scl = 1'b1;
        #18 s = sda;
        scl = 1'b0;
        #6;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], s);
        xfer_bit(1'b1, ack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, s);
            d[i] = s;
        end
        xfer_bit(nack, s);
    endtask
endmodule // i2c_master_model

// >>> amp_i2c_control_fault_monitor_tb.sv
`timescale 1ns/1ps
module amp_i2c_control_fault_monitor_tb
    import amp_pkg::*;
;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic standby_n = 1'b1;
    logic mute = 1'b0;
    logic por = 1'b0;
    logic [5:0] evt = '0;
    logic [3:0] diag = '0;
    logic scl, sda_drv, sda_out, sda_oe_n, fault_out, fault_oe_n;
    logic output_hiz, output_mute, switch_freq_sel, peak_limit_enable;
    logic [1:0] gain_sel;
    logic [2:0] peak_limit_sel;
    logic [7:0] rd [4];
    wire sda = sda_drv & (sda_oe_n | sda_out);
    wire [6:0] ctl_o = {gain_sel, switch_freq_sel, peak_limit_sel,
        peak_limit_enable};
    int mismatches = 0;
    int n_checks = 0;

    always #2.5 clock = ~clock;

    i2c_master_model i2c_master_model_inst (.scl(scl), .sda_drv(sda_drv),
        .sda(sda));
    amp_i2c_control_fault_monitor #(.WAKE_CYCLES(20))
    amp_i2c_control_fault_monitor_inst (.clock(clock), .nrst(nrst),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .standby_n(standby_n), .mute(mute),
        .overcurrent_shutdown(evt[0]), .dc_offset_detect(evt[1]),
        .thermal_shutdown(evt[2]), .supply_low_detect(evt[3]),
        .supply_high_detect(evt[4]), .por_detect(por),
        .short_to_supply(evt[5]), .short_to_ground(diag[0]),
        .open_load(diag[1]), .shorted_load(diag[2]),
        .diag_running(diag[3]),
        .fault_out(fault_out), .fault_oe_n(fault_oe_n),
        .output_hiz(output_hiz), .output_mute(output_mute),
        .gain_sel(gain_sel), .switch_freq_sel(switch_freq_sel),
        .peak_limit_sel(peak_limit_sel),
        .peak_limit_enable(peak_limit_enable));

    task automatic complete_run();
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic a0, a1, a2;
        i2c_master_model_inst.start();
        i2c_master_model_inst.wbyte({SLAVE_ADDR, 1'b0}, a0);
        i2c_master_model_inst.wbyte(idx, a1);
        i2c_master_model_inst.wbyte(d, a2);
        i2c_master_model_inst.stop();
        check(8'({a0, a1, a2}), 8'h00);
    endtask
    task automatic rreg(input logic [7:0] idx, input int n);
        logic a0, a1, a2;
        i2c_master_model_inst.start();
        i2c_master_model_inst.wbyte({SLAVE_ADDR, 1'b0}, a0);
        i2c_master_model_inst.wbyte(idx, a1);
        i2c_master_model_inst.start();
        i2c_master_model_inst.wbyte({SLAVE_ADDR, 1'b1}, a2);
        for (int i = 0; i < n; i++) begin
            i2c_master_model_inst.rbyte(i == n - 1, rd[i]);
        end
        i2c_master_model_inst.stop();
        check(8'({a0, a1, a2}), 8'h00);
    endtask
    // Addresses a frame to some address and returns its acknowledge
    task automatic probe(input logic [7:0] a, output logic ack);
        i2c_master_model_inst.start();
        i2c_master_model_inst.wbyte(a, ack);
        i2c_master_model_inst.stop();
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        complete_run();
    end

    initial begin
        logic [7:0] v;
        logic a;
        int fb [6];
        fb = '{FLT_OC, FLT_DC, FLT_OT, FLT_UV, FLT_OV, FLT_DIAG};
        cyc(10);
        nrst = 1'b1;
        cyc(40);
        check(8'(ctl_o), 8'({2'b01, 1'b0, LIMIT_OFF, 1'b0}));
        rreg(IDX_FAULT, 3);
        check(rd[0], FAULT_RESET);
        check(rd[1], 8'h80);
        check(rd[2], CTRL_RESET);
        // Reserved bits written as ones must read back as zero
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], 3'(2 * i + 1), 2'b11, i[0]};
            wreg(IDX_CTRL, v);
            cyc(8);
            rreg(IDX_CTRL, 1);
            check(rd[0], v & CTRL_WRITE_MASK);
            check(8'(ctl_o), 8'({v[7:6], v[0], v[5:3], i != 3}));
        end
        wreg(IDX_FAULT, 8'hFF);
        rreg(IDX_FAULT, 1);
        check(rd[0], FAULT_RESET);
        probe(8'hA0, a);
        check(8'(a), 8'h01);
        for (int k = 0; k < 6; k++) begin
            evt = 6'(1 << k);
            cyc(6);
            check(8'({fault_oe_n, fault_out, output_hiz}), 8'h01);
            evt = '0;
            cyc(6);
            check(8'(fault_oe_n), 8'h01);
            if (k == 3) check(8'(gain_sel), 8'h01);
            rreg(IDX_FAULT, 1);
            check(rd[0], 8'(1 << fb[k]));
            rreg(IDX_FAULT, 1);
            check(rd[0], FAULT_RESET);
        end
        mute = 1'b1;
        cyc(6);
        check(8'(output_mute), 8'h01);
        rreg(IDX_STATUS, 1);
        check(rd[0], 8'h40);
        mute = 1'b0;
        cyc(6);
        check(8'(output_mute), 8'h00);
        // Open load alone is only reported, never faults the stage
        diag = 4'h2;
        cyc(6);
        check(8'({fault_oe_n, output_hiz}), 8'h02);
        diag = 4'hF;
        cyc(6);
        rreg(IDX_STATUS, 1);
        check(rd[0], 8'h3E);
        diag = 4'h0;
        cyc(6);
        wreg(IDX_CTRL, 8'h41);
        por = 1'b1;
        cyc(8);
        check(8'({sda_oe_n, fault_oe_n}), 8'h03);
        probe({SLAVE_ADDR, 1'b0}, a);
        check(8'(a), 8'h01);
        por = 1'b0;
        cyc(40);
        rreg(IDX_CTRL, 1);
        check(rd[0], CTRL_RESET);
        // Own address goes unacknowledged through standby
        standby_n = 1'b0;
        cyc(6);
        probe({SLAVE_ADDR, 1'b0}, a);
        check(8'(a), 8'h01);
        standby_n = 1'b1;
        cyc(40);
        rreg(IDX_CTRL, 1);
        check(rd[0], CTRL_RESET);
        complete_run();
    end
endmodule // amp_i2c_control_fault_monitor_tb
